// File: dv/mccc_checker.sv
// Port checker for the cam switch, capture and counter block.
// Assumes it is bound to mccc_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module mccc_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire mccc_pkg::mccc_bus_t bus,
  input wire logic [31:0] rdata,
  input wire logic [3:0] digital_in,
  input wire logic [2:0] encoder_abz,
  input wire mccc_pkg::mccc_pos_t pos,
  input wire logic [5:0] track_out,
  input wire logic [5:0] motion_out,
  input wire logic motion_busy,
  input wire logic [2:0] motion_trigger
);
  import mccc_pkg::*;
  // **
  // Mode shadow
  // **
  logic mode_q;
  logic [15:0] idx;
  assign idx = bus.addr[23:8];
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode_q <= 1'b0;
    end else if (bus.wr && bus.addr == {IDX_MODULE_OPERATING_MODE, 8'h00}) begin
      mode_q <= bus.wdata[0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // **
  // Properties
  // **
  property p_rd_idle; !$past(bus.rd) |-> rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_mode_rd; bus.rd && idx == IDX_MODULE_OPERATING_MODE |=> rdata == {31'h0, mode_q};
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("bad mode read");
  property p_mode_trk; mode_q [*3] |-> track_out == 6'h00; endproperty
  a_mode_trk: assert property (p_mode_trk) else $error("tracks on in counter mode");
  property p_stat_rd; bus.rd && idx == IDX_CAPTURE_STATUS |=> rdata[31:5] == 27'h0; endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("status spare bits");
  property p_trig_rd; bus.rd && idx == IDX_MOTION_TRIGGER_SETTING |=> rdata[31:5] == 27'h0;
  endproperty
  a_trig_rd: assert property (p_trig_rd) else $error("trigger spare bits");
  property p_mo_rd; bus.rd && idx == IDX_MOTION_OUTPUT_SETTING |=> rdata[14:6] == 9'h000;
  endproperty
  a_mo_rd: assert property (p_mo_rd) else $error("output spare bits");
  property p_cs_rd; bus.rd && idx == IDX_CAPTURE_SETTING |=> rdata[31:20] == 12'h0 && !rdata[14];
  endproperty
  a_cs_rd: assert property (p_cs_rd) else $error("capture spare bits");
  property p_trig_one; motion_trigger != 3'h0 |=> (motion_trigger & $past(motion_trigger)) == 3'h0;
  endproperty
  a_trig_one: assert property (p_trig_one) else $error("trigger pulse too long");
  property p_trig_src;
    motion_trigger != 3'h0 |-> $past({encoder_abz, digital_in}) != $past({encoder_abz, digital_in}, 2);
  endproperty
  a_trig_src: assert property (p_trig_src) else $error("trigger without edge");
  property p_ctl_rd; bus.rd && bus.addr == {IDX_INPUT_COUNTER_FUNCTION, 8'h03}
    |=> rdata[31:8] == 24'h0 && rdata[6:1] == 6'h00; endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("control spare bits");
  property p_mo_hold; $rose(|motion_out) |-> (|motion_out) [*8]; endproperty
  a_mo_hold: assert property (p_mo_hold) else $error("output pulse too short");
  c_trig: cover property (motion_trigger != 3'h0);
  c_busy: cover property ($rose(motion_busy));
  c_trk: cover property (track_out != 6'h00);
  c_mode: cover property (mode_q [*3]);
endmodule
bind mccc_top mccc_checker u_chk (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
  .digital_in(digital_in), .encoder_abz(encoder_abz), .pos(pos), .track_out(track_out),
  .motion_out(motion_out), .motion_busy(motion_busy), .motion_trigger(motion_trigger));
`default_nettype wire

// File: dv/mccc_partner.sv
// Model of the input lines, encoder lines and axis positions.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ps
`default_nettype none
module mccc_partner (
  input wire logic mclk,
  output logic [3:0] digital_in,
  output logic [2:0] encoder_abz,
  output var mccc_pkg::mccc_pos_t pos
);
  import mccc_pkg::*;
  initial begin
    digital_in = 4'h0;
    encoder_abz = 3'h0;
    pos = '0;
  end
  // Lines 0 to 3 are inputs, 4 to 6 encoder A, B, Z
  task automatic set_line(input int b, input logic x);
    @(posedge mclk);
    if (b < 4) digital_in[b] <= x;
    else encoder_abz[b - 4] <= x;
  endtask
  task automatic pulses(input int b, input int n);
    repeat (n) begin
      set_line(b, 1'b1);
      set_line(b, 1'b0);
    end
  endtask
  task automatic set_pos(input logic [127:0] x, input logic [1:0] mv);
    @(posedge mclk);
    pos <= {x, mv};
  endtask
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the cam switch, capture and counter block.
// Assumes the partner model drives input lines and positions.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mccc_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  mccc_bus_t bus = '0;
  logic [31:0] rdata, d, iv;
  logic [31:0] v [4];
  logic [31:0] w [6];
  logic [3:0] digital_in;
  logic [2:0] encoder_abz;
  mccc_pos_t pos;
  logic [5:0] track_out, motion_out, m0, m1;
  logic motion_busy, e, mp, on;
  logic [2:0] motion_trigger;
  integer seed = 32'hCB97;
  int n_mismatch = 0;
  int cmp_count = 0;
  int s, t, n;
  logic [23:0] ra [4] = '{{IDX_MOTION_TRIGGER_SETTING, 8'h01}, {IDX_CAPTURE_SETTING, 8'h01},
    {IDX_MOTION_OUTPUT_SETTING, 8'h01}, {IDX_MODULE_OPERATING_MODE, 8'h00}};
  logic [31:0] rm [4] = '{32'h1F, 32'hFB0FF, 32'hFFFF803F, 32'h1};
  localparam logic [23:0] CTL = {IDX_INPUT_COUNTER_FUNCTION, 8'h03};
  localparam logic [23:0] CNT = {IDX_INPUT_COUNTER_FUNCTION, 8'h01};
  localparam logic [23:0] FN = {IDX_DI2_FUNCTION, 8'h00};
  localparam logic [23:0] FIRE = {IDX_MOTION_OUTPUT_FIRE, 8'h00};
  localparam logic [23:0] MODE = {IDX_MODULE_OPERATING_MODE, 8'h00};
  always #2 mclk = ~mclk;
  mccc_top dut (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .digital_in(digital_in),
    .encoder_abz(encoder_abz), .pos(pos), .track_out(track_out), .motion_out(motion_out),
    .motion_busy(motion_busy), .motion_trigger(motion_trigger));
  mccc_partner p (.mclk(mclk), .digital_in(digital_in), .encoder_abz(encoder_abz), .pos(pos));
  // **
  // Bus tasks and checks
  // **
  task automatic wr(input logic [23:0] a, input logic [31:0] x);
    @(posedge mclk);
    bus.addr <= a;
    bus.wdata <= x;
    bus.wr <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [23:0] a, input logic [31:0] exp);
    @(posedge mclk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic trig(input int b, input logic x, input int k, input int exp);
    int c;
    c = 0;
    p.set_line(b, x);
    repeat (5) begin
      @(posedge mclk);
      #1 c += int'(motion_trigger[k] === 1'b1);
    end
    chk(32'(c), 32'(exp));
  endtask
  function automatic logic cam_on(input int dir, input logic mv);
    return dir == 0 || (dir == 1 && mv) || (dir == 2 && !mv);
  endfunction
  function automatic logic [31:0] cap_word(input int src, input int tgt, input logic rise);
    return {19'h0, rise, 4'h0, 4'(src), 4'(tgt)};
  endfunction
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    finish_test();
  end
  // **
  // Main sequence
  // **
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    rc(MODE, 32'h0);
    rc({IDX_CAPTURE_STATUS, 8'h01}, 32'h0);
    rc({IDX_INPUT_COUNTER_FUNCTION, 8'h07}, 32'h000003E8);
    wr({IDX_INPUT_COUNTER_FUNCTION, 8'h06}, 32'h1);
    rc({IDX_INPUT_COUNTER_FUNCTION, 8'h06}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      wr(ra[i], d);
      rc(ra[i], d & rm[i]);
    end
    wr(MODE, 32'h0);
    wr(24'h500001, 32'hFFFFFFFF);
    rc(24'h500001, 32'h0);
    for (int c = 0; c < 7; c++) begin
      e = c[0];
      wr({IDX_MOTION_TRIGGER_SETTING, 8'(c % 3 + 1)}, {27'h0, e, 4'(c)});
      p.set_line(c, !e);
      repeat (3) @(posedge mclk);
      trig(c, e, c % 3, 1);
      trig(c, !e, c % 3, 0);
    end
    for (int ch = 0; ch < CAP_N; ch++) begin
      s = $unsigned($random(seed)) % 7;
      t = $unsigned($random(seed)) % 4;
      e = 1'($random(seed));
      foreach (v[k]) v[k] = $random(seed);
      p.set_line(s, !e);
      wr({IDX_CAPTURE_SETTING, 8'(ch + 1)}, cap_word(s, t, e));
      wr({IDX_CAPTURE_ENABLE, 8'h01}, 32'h1 << ch);
      p.set_pos({v[0], v[1], v[2], v[3]}, 2'b10);
      p.set_line(s, e);
      repeat (3) @(posedge mclk);
      rc({IDX_CAPTURE_VALUE, 8'(ch + 1)}, v[t]);
      rc({IDX_CAPTURE_STATUS, 8'h01}, (32'h2 << ch) - 32'h1);
    end
    wr({IDX_CAPTURE_VALUE, 8'h05}, ~v[t]);
    rc({IDX_CAPTURE_VALUE, 8'h05}, v[t]);
    wr({IDX_CAPTURE_STATUS, 8'h01}, 32'h1F);
    rc({IDX_CAPTURE_STATUS, 8'h01}, 32'h0);
    iv = $random(seed);
    p.set_line(2, 1'b0);
    wr(FN, 32'hA);
    wr({IDX_INPUT_COUNTER_FUNCTION, 8'h04}, iv);
    wr(CTL, 32'h81);
    rc(CTL, 32'h1);
    p.pulses(2, 9);
    repeat (3) @(posedge mclk);
    rc(CNT, iv + 32'h9);
    wr(FN, 32'h0);
    p.pulses(2, 4);
    rc(CNT, iv + 32'h9);
    wr(CTL, 32'h81);
    rc(CNT, iv);
    for (int i = 0; i < 6; i++) begin
      n = $unsigned($random(seed)) % CAM_N;
      t = $unsigned($random(seed)) % TRK_N;
      s = (i == 5) ? 0 : $unsigned($random(seed)) % 3;
      mp = 1'($random(seed));
      d = $random(seed) & 32'h0FFFFFFF;
      w = '{32'(t), d, d + 32'h3E8, 32'(s), 32'(i == 5), 32'h1};
      for (int k = 0; k < 6; k++) wr({IDX_CAM_SWITCH_TABLE, 8'(6 * n + k + 1)}, w[k]);
      wr({IDX_CAM_ENABLE, 8'h00}, 32'h1 << n);
      p.set_pos({d + 32'h1F4, 96'h0}, {mp, !mp});
      repeat (250) @(posedge mclk);
      on = cam_on(s, mp);
      chk(32'(track_out[t]), 32'(on));
      p.set_pos({d + 32'h3E9, 96'h0}, {mp, !mp});
      repeat (250) @(posedge mclk);
      chk(32'(track_out[t]), 32'(on && i == 5));
    end
    wr(MODE, 32'h1);
    repeat (4) @(posedge mclk);
    chk(32'(track_out), 32'h0);
    wr(MODE, 32'h0);
    m0 = 6'($random(seed));
    m1 = 6'($random(seed));
    wr({IDX_MOTION_OUTPUT_SETTING, 8'h02}, {16'h0001, 1'b1, 9'h000, m1});
    wr(FIRE, 32'h2);
    repeat (4) @(posedge mclk);
    chk({25'h0, motion_busy, motion_out}, {25'h0, 1'b0, m1});
    wr({IDX_MOTION_OUTPUT_SETTING, 8'h01}, {16'h0001, 1'b0, 9'h000, m0});
    wr(FIRE, 32'h1);
    repeat (200) @(posedge mclk);
    chk({25'h0, motion_busy, motion_out}, {25'h0, 1'b1, m0 | m1});
    finish_test();
  end
endmodule
`default_nettype wire

// File: shared/mccc_pkg.sv
// Package for the motion cam switch, capture and counter block.
// Assumes a single 250 MHz clock and word-wide register port.
package mccc_pkg;
  // **
  // Register map
  // **
  localparam logic [15:0] IDX_CAM_SWITCH_TABLE = 16'h5583;
  localparam logic [15:0] IDX_MOTION_OUTPUT_SETTING = 16'h558F;
  localparam logic [15:0] IDX_CAPTURE_ENABLE = 16'h5590;
  localparam logic [15:0] IDX_CAPTURE_STATUS = 16'h5591;
  localparam logic [15:0] IDX_CAPTURE_SETTING = 16'h5592;
  localparam logic [15:0] IDX_CAPTURE_VALUE = 16'h5598;
  localparam logic [15:0] IDX_MOTION_TRIGGER_SETTING = 16'h559F;
  localparam logic [15:0] IDX_INPUT_COUNTER_FUNCTION = 16'h55C0;
  localparam logic [15:0] IDX_MODULE_OPERATING_MODE = 16'h55F0;
  // Extra registers
  localparam logic [15:0] IDX_DI2_FUNCTION = 16'h55E0;
  localparam logic [15:0] IDX_CAM_ENABLE = 16'h55E1;
  localparam logic [15:0] IDX_MOTION_OUTPUT_FIRE = 16'h55E2;
  // Address layout: [23:8] index, [7:0] sub index
  localparam int ADDR_W = 24;
  localparam int IDX_LSB = 8;
  localparam int CAM_SUBS = 6;
  localparam int CAM_N = 16;
  localparam int CAP_N = 5;
  localparam int TRK_N = 6;
  // **
  // Field positions
  // **
  localparam int MO_DUR_LSB = 16;
  localparam int MO_NONBLOCK_BIT = 15;
  localparam int CS_IVAL_LSB = 16;
  localparam int CS_IVAL_MODE_BIT = 15;
  localparam int CS_CONT_BIT = 13;
  localparam int CS_RISE_BIT = 12;
  localparam int CS_SRC_LSB = 4;
  localparam int MT_RISE_BIT = 4;
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_RESTART_BIT = 7;
  localparam logic [7:0] DI2_COUNTER_FUNC = 8'h0A;
  localparam logic [15:0] SAMPLE_MS_RESET = 16'd1000;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [3:0] TGT_TIMER = 4'h4;
  // **
  // Timing
  // **
  localparam int CLK_MHZ = 250;
  localparam int TIMER_NS = 250;
  localparam int TIMER_CYC = TIMER_NS * CLK_MHZ / 1000;
  localparam int MS_US = 1000;
  localparam int MS_CYC = MS_US * CLK_MHZ;
  typedef enum logic [1:0] {
    MCCC_DIR_BOTH = 2'b00,
    MCCC_DIR_POS = 2'b01,
    MCCC_DIR_NEG = 2'b10
  } mccc_dir_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } mccc_bus_t;
  typedef struct packed {
    logic [31:0] cmd_pos;
    logic [31:0] add1_pos;
    logic [31:0] act_pos;
    logic [31:0] add2_pos;
    logic moving_pos;
    logic moving_neg;
  } mccc_pos_t;
endpackage

// File: verilog/mccc_cam_mem.sv
// Cam switch table memory, 16 entries by 6 sub index words.
// Assumes one write port and one registered read port.
`timescale 1ns/1ps
`default_nettype none
module mccc_cam_mem (
  input wire logic mclk,
  input wire logic we,
  input wire logic [6:0] waddr,
  input wire logic [31:0] wdata,
  input wire logic [6:0] raddr,
  output logic [31:0] rdata
);
  import mccc_pkg::*;
  logic [31:0] mem_q [0:CAM_N*CAM_SUBS-1];
  always_ff @(posedge mclk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end
  always_ff @(posedge mclk) begin
    rdata <= mem_q[raddr];
  end
endmodule
`default_nettype wire

// File: verilog/mccc_top.sv
// Cam switch, pulsed output, capture, trigger and counter block.
// Assumes synchronous inputs and a register master that never waits.
// Notes on behaviour
// R1: Sixteen cam switches, track field 0 to 5 picks one of six outputs.
// R2: Position mode: track on while position lies between lower and upper bound.
// R3: Direction qualifier: 0 both, 1 positive only, 2 negative only.
// R4: Mode field: 0 position based, 1 time based.
// R5: Time mode holds track on for programmed 1 to 16000 ms.
// R6: Output word: duration ms in bits 31:16, bit 15 non-blocking.
// R7: Output word bits 0 to 5 enable four outputs and two pulse lines.
// R8: Capture enable bits 0 to 4, one per channel.
// R9: Capture status bit set means channel has captured a value.
// R10: Software keeps capture interval above one millisecond.
// R11: Clockwise/counterclockwise input method forbids capture targets 2 to 4.
// R12: Five capture channels with setting words at sub index 1 to 5.
// R13: Setting bits 19:16 relate channels, used with interval mode bit.
// R14: Three triggers pick input 0 to 6, bit selects rising or falling.
// R15: Third digital input counts when its function selection equals 10.
// R16: Software avoids pulse method 1 while third input counts.
// R17: Control bit 0 enables counting, bit 7 restart clears itself.
// R18: Computed value over sampling ms, frequency or difference mode.
// R19: Module mode 0 motion, 1 counter.
// R20: Software sets module mode before axis power goes active.
// R21: Enabled channel latches target on chosen edge and sets status.
// R22: Restart reloads initial value before counting resumes.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module mccc_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire mccc_pkg::mccc_bus_t bus,
  output logic [31:0] rdata,
  input wire logic [3:0] digital_in,
  input wire logic [2:0] encoder_abz,
  input wire mccc_pkg::mccc_pos_t pos,
  output logic [5:0] track_out,
  output logic [5:0] motion_out,
  output logic motion_busy,
  output logic [2:0] motion_trigger
);
  import mccc_pkg::*;
  // **
  // Register decode
  // **
  logic [15:0] idx;
  logic [7:0] sub;
  assign idx = bus.addr[ADDR_W-1:IDX_LSB];
  assign sub = bus.addr[IDX_LSB-1:0];
  logic [31:0] mo_set_q [0:2];
  logic [5:0] cap_en_q;
  logic [5:0] cap_stat_q;
  logic [31:0] cap_set_q [0:CAP_N-1];
  logic [31:0] cap_val_q [0:CAP_N-1];
  logic [7:0] mt_set_q [0:2];
  logic [31:0] cnt_val_q, cmp_val_q, init_val_q;
  logic [7:0] ctl_q;
  logic cmp_mode_q;
  logic [15:0] samp_ms_q;
  logic [7:0] mode_q, di2_func_q;
  logic [15:0] cam_en_q;
  logic [2:0] fire_q;
  logic [6:0] cam_rsel;
  logic [31:0] cam_rdata;
  logic cam_we;
  logic [6:0] cam_waddr;
  assign cam_we = bus.wr && idx == IDX_CAM_SWITCH_TABLE && sub != 8'h00
    && sub <= 8'(CAM_N * CAM_SUBS);
  assign cam_waddr = 7'(sub - 8'h01);
  // **
  // Cam table and scanner
  // **
  // The scanner walks entries; a read of the table borrows the port
  logic [3:0] scan_q, scan_d;
  logic [2:0] ph_q;
  logic [31:0] ent_q [0:CAM_SUBS-1];
  logic rd_cam_q;
  assign cam_rsel = bus.rd && idx == IDX_CAM_SWITCH_TABLE ? 7'(sub - 8'h01)
    : 7'(scan_q * CAM_SUBS + 32'(ph_q));
  mccc_cam_mem u_mem (
    .mclk(mclk),
    .we(cam_we),
    .waddr(cam_waddr),
    .wdata(bus.wdata),
    .raddr(cam_rsel),
    .rdata(cam_rdata)
  );
  logic ph_valid_q;
  logic [2:0] ph_prev_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ph_q <= 3'h0;
      scan_q <= 4'h0;
      ph_valid_q <= 1'b0;
      ph_prev_q <= 3'h0;
    end else begin
      ph_valid_q <= !(bus.rd && idx == IDX_CAM_SWITCH_TABLE);
      ph_prev_q <= ph_q;
      if (!(bus.rd && idx == IDX_CAM_SWITCH_TABLE)) begin
        if (ph_q == 3'(CAM_SUBS - 1)) begin
          ph_q <= 3'h0;
          scan_q <= scan_d;
        end else begin
          ph_q <= ph_q + 3'h1;
        end
      end
    end
  end
  assign scan_d = scan_q + 4'h1;
  logic [3:0] scan_prev_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scan_prev_q <= 4'h0;
    end else begin
      scan_prev_q <= scan_q;
    end
  end
  always_ff @(posedge mclk) begin
    if (ph_valid_q) begin
      ent_q[ph_prev_q] <= cam_rdata;
    end
  end
  // Evaluate once an entry is fetched
  logic eval;
  assign eval = ph_valid_q && ph_prev_q == 3'(CAM_SUBS - 1);
  logic [CAM_N-1:0] cam_on_q;
  logic [15:0] cam_ms_q [0:CAM_N-1];
  logic [17:0] ms_div_q;
  logic ms_tick;
  assign ms_tick = ms_div_q == 18'(MS_CYC - 1);
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ms_div_q <= 18'h0;
    end else begin
      ms_div_q <= ms_tick ? 18'h0 : ms_div_q + 18'h1;
    end
  end
  logic [31:0] cur_pos, lo_b, hi_b;
  logic dir_ok, in_win;
  logic [31:0] ent_last;
  assign ent_last = cam_rdata;
  assign lo_b = ent_q[1];
  assign hi_b = ent_q[2];
  always_comb begin
    cur_pos = ent_q[0][8] ? pos.act_pos : pos.cmd_pos;
    in_win = $signed(cur_pos) >= $signed(lo_b) && $signed(cur_pos) <= $signed(hi_b); // R2
    case (mccc_dir_t'(ent_q[3][1:0])) // R3
      MCCC_DIR_BOTH: dir_ok = 1'b1;
      MCCC_DIR_POS: dir_ok = pos.moving_pos;
      MCCC_DIR_NEG: dir_ok = pos.moving_neg;
      default: dir_ok = 1'b0;
    endcase
  end
  genvar g;
  generate
    for (g = 0; g < CAM_N; g++) begin : g_cam
      always_ff @(posedge mclk) begin
        if (!rst_n || !cam_en_q[g]) begin
          cam_on_q[g] <= 1'b0;
          cam_ms_q[g] <= 16'h0;
        end else if (eval && scan_prev_q == 4'(g)) begin
          if (ent_q[4][0] == 1'b0) begin // R4
            cam_on_q[g] <= in_win && dir_ok; // R2
          end else if (in_win && dir_ok && cam_ms_q[g] == 16'h0 && !cam_on_q[g]) begin
            cam_on_q[g] <= 1'b1; // R5
            cam_ms_q[g] <= ent_last[15:0];
          end
        end else if (ms_tick && cam_ms_q[g] != 16'h0) begin
          cam_ms_q[g] <= cam_ms_q[g] - 16'h1;
          if (cam_ms_q[g] == 16'h1) begin
            cam_on_q[g] <= 1'b0; // R5
          end
        end
      end
    end
  endgenerate
  // Track of each switch
  logic [2:0] cam_trk_q [0:CAM_N-1];
  always_ff @(posedge mclk) begin
    if (eval) begin
      cam_trk_q[scan_prev_q] <= ent_q[0][2:0]; // R1
    end
  end
  logic [5:0] trk_d;
  always_comb begin
    trk_d = 6'h00;
    for (int i = 0; i < CAM_N; i++) begin
      if (cam_on_q[i] && cam_trk_q[i] < 3'(TRK_N)) begin
        trk_d[cam_trk_q[i]] = 1'b1; // R1
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      track_out <= 6'h00;
    end else begin
      track_out <= mode_q == MODE_RESET ? trk_d : 6'h00; // R19
    end
  end
  // **
  // Motion outputs
  // **
  logic [15:0] mo_ms_q [0:2];
  logic [2:0] mo_blk_q;
  generate
    for (g = 0; g < 3; g++) begin : g_mo
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          mo_ms_q[g] <= 16'h0;
          mo_blk_q[g] <= 1'b0;
        end else if (fire_q[g]) begin
          mo_ms_q[g] <= mo_set_q[g][31:MO_DUR_LSB]; // R6
          mo_blk_q[g] <= !mo_set_q[g][MO_NONBLOCK_BIT]; // R6
        end else if (ms_tick && mo_ms_q[g] != 16'h0) begin
          mo_ms_q[g] <= mo_ms_q[g] - 16'h1;
        end
      end
    end
  endgenerate
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      motion_out <= 6'h00;
      motion_busy <= 1'b0;
    end else begin
      motion_out <= (mo_ms_q[0] != 16'h0 ? mo_set_q[0][5:0] : 6'h00) // R7
        | (mo_ms_q[1] != 16'h0 ? mo_set_q[1][5:0] : 6'h00)
        | (mo_ms_q[2] != 16'h0 ? mo_set_q[2][5:0] : 6'h00);
      motion_busy <= (mo_blk_q[0] && mo_ms_q[0] != 16'h0)
        || (mo_blk_q[1] && mo_ms_q[1] != 16'h0)
        || (mo_blk_q[2] && mo_ms_q[2] != 16'h0); // R6
    end
  end
  // **
  // Triggers and capture
  // **
  logic [6:0] src, src_q;
  assign src = {encoder_abz, digital_in};
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      src_q <= 7'h00;
    end else begin
      src_q <= src;
    end
  end
  logic [6:0] rise, fall;
  assign rise = src & ~src_q;
  assign fall = ~src & src_q;
  generate
    for (g = 0; g < 3; g++) begin : g_mt
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          motion_trigger[g] <= 1'b0;
        end else begin
          motion_trigger[g] <= mt_set_q[g][3:0] < 4'd7 && (mt_set_q[g][MT_RISE_BIT] // R14
            ? rise[mt_set_q[g][2:0]] : fall[mt_set_q[g][2:0]]);
        end
      end
    end
  endgenerate
  logic [7:0] tmr_div_q;
  logic [31:0] timer_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tmr_div_q <= 8'h0;
      timer_q <= 32'h0;
    end else if (tmr_div_q == 8'(TIMER_CYC - 1)) begin
      tmr_div_q <= 8'h0;
      timer_q <= timer_q + 32'h1;
    end else begin
      tmr_div_q <= tmr_div_q + 8'h1;
    end
  end
  logic [CAP_N-1:0] cap_hit;
  generate
    for (g = 0; g < CAP_N; g++) begin : g_cap
      logic [3:0] s;
      logic edge_ok, gate_ok;
      logic [3:0] rel;
      assign s = cap_set_q[g][CS_SRC_LSB+3:CS_SRC_LSB];
      assign rel = cap_set_q[g][CS_IVAL_LSB+3:CS_IVAL_LSB];
      assign edge_ok = s < 4'd7 && (cap_set_q[g][CS_RISE_BIT] ? rise[s[2:0]] : fall[s[2:0]]);
      // Interval mode waits for related channel
      assign gate_ok = !cap_set_q[g][CS_IVAL_MODE_BIT]
        || (rel < 4'(CAP_N) && cap_stat_q[rel[2:0]]); // R13
      assign cap_hit[g] = cap_en_q[g] && edge_ok && gate_ok
        && (cap_set_q[g][CS_CONT_BIT] || !cap_stat_q[g]); // R21
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          cap_val_q[g] <= 32'h0;
        end else if (cap_hit[g]) begin
          case (cap_set_q[g][3:0]) // R21
            4'h0: cap_val_q[g] <= pos.cmd_pos;
            4'h1: cap_val_q[g] <= pos.add1_pos;
            4'h2: cap_val_q[g] <= pos.act_pos;
            4'h3: cap_val_q[g] <= pos.add2_pos;
            TGT_TIMER: cap_val_q[g] <= timer_q;
            default: cap_val_q[g] <= cap_val_q[g];
          endcase
        end
      end
    end
  endgenerate
  // **
  // Counter
  // **
  logic cnt_act;
  logic [15:0] samp_left_q;
  logic [31:0] cnt_base_q;
  assign cnt_act = di2_func_q == DI2_COUNTER_FUNC && ctl_q[CTL_EN_BIT]; // R15 R17
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_val_q <= 32'h0;
    end else if (ctl_q[CTL_RESTART_BIT]) begin
      cnt_val_q <= init_val_q; // R22
    end else if (cnt_act && rise[2]) begin
      cnt_val_q <= cnt_val_q + 32'h1; // R15
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n || ctl_q[CTL_RESTART_BIT]) begin
      samp_left_q <= 16'h0;
      cnt_base_q <= init_val_q;
      cmp_val_q <= 32'h0;
    end else if (cnt_act && ms_tick) begin
      if (samp_left_q <= 16'h1) begin
        samp_left_q <= samp_ms_q;
        cnt_base_q <= cnt_val_q;
        cmp_val_q <= cmp_mode_q ? cnt_val_q - cnt_base_q // R18
          : 32'((64'(cnt_val_q - cnt_base_q) * 64'(MS_US))
            / 64'(samp_ms_q == 16'h0 ? 16'h1 : samp_ms_q));
      end else begin
        samp_left_q <= samp_left_q - 16'h1;
      end
    end
  end
  // **
  // Register writes
  // **
  logic in_sub3, in_sub5;
  assign in_sub3 = sub >= 8'h01 && sub <= 8'h03;
  assign in_sub5 = sub >= 8'h01 && sub <= 8'h05;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        mo_set_q[i] <= 32'h0;
        mt_set_q[i] <= 8'h0;
      end
      for (int i = 0; i < CAP_N; i++) begin
        cap_set_q[i] <= 32'h0;
      end
      cap_en_q <= 6'h00;
      init_val_q <= 32'h0;
      ctl_q <= 8'h00;
      cmp_mode_q <= 1'b0;
      samp_ms_q <= SAMPLE_MS_RESET;
      mode_q <= MODE_RESET;
      di2_func_q <= 8'h00;
      cam_en_q <= 16'h0000;
      fire_q <= 3'h0;
    end else begin
      fire_q <= 3'h0;
      ctl_q[CTL_RESTART_BIT] <= 1'b0; // R17
      if (bus.wr) begin
        case (idx)
          IDX_MOTION_OUTPUT_SETTING: if (in_sub3) mo_set_q[sub[1:0]-2'h1] <= bus.wdata & 32'hFFFF_803F; // R7
          IDX_CAPTURE_ENABLE: cap_en_q <= bus.wdata[5:0]; // R8
          IDX_CAPTURE_SETTING: if (in_sub5) cap_set_q[sub[2:0]-3'h1] <= bus.wdata & 32'h000F_B0FF; // R12
          IDX_MOTION_TRIGGER_SETTING: if (in_sub3) mt_set_q[sub[1:0]-2'h1] <= bus.wdata[7:0] & 8'h1F;
          IDX_INPUT_COUNTER_FUNCTION: begin
            case (sub)
              8'h03: ctl_q <= bus.wdata[7:0] & 8'h81; // R17
              8'h04: init_val_q <= bus.wdata;
              8'h06: cmp_mode_q <= bus.wdata[0]; // R18
              8'h07: samp_ms_q <= bus.wdata[15:0]; // R18
              default: ;
            endcase
          end
          IDX_MODULE_OPERATING_MODE: mode_q <= bus.wdata[7:0] & 8'h01; // R19
          IDX_DI2_FUNCTION: di2_func_q <= bus.wdata[7:0];
          IDX_CAM_ENABLE: cam_en_q <= bus.wdata[15:0];
          IDX_MOTION_OUTPUT_FIRE: fire_q <= bus.wdata[2:0];
          default: ;
        endcase
      end
    end
  end
  // Capture beats a same-cycle clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cap_stat_q <= 6'h00;
    end else begin
      for (int i = 0; i < CAP_N; i++) begin
        if (cap_hit[i]) begin
          cap_stat_q[i] <= 1'b1; // R9
        end else if (bus.wr && idx == IDX_CAPTURE_STATUS && bus.wdata[i]) begin
          cap_stat_q[i] <= 1'b0;
        end
      end
      cap_stat_q[5] <= 1'b0;
    end
  end
  // **
  // Register reads
  // **
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0;
    case (idx)
      IDX_MOTION_OUTPUT_SETTING: if (in_sub3) rd_d = mo_set_q[sub[1:0]-2'h1];
      IDX_CAPTURE_ENABLE: rd_d = {26'h0, cap_en_q};
      IDX_CAPTURE_STATUS: rd_d = {26'h0, cap_stat_q};
      IDX_CAPTURE_SETTING: if (in_sub5) rd_d = cap_set_q[sub[2:0]-3'h1];
      IDX_CAPTURE_VALUE: if (in_sub5) rd_d = cap_val_q[sub[2:0]-3'h1];
      IDX_MOTION_TRIGGER_SETTING: if (in_sub3) rd_d = {24'h0, mt_set_q[sub[1:0]-2'h1]};
      IDX_INPUT_COUNTER_FUNCTION: begin
        case (sub)
          8'h01: rd_d = cnt_val_q;
          8'h02: rd_d = cmp_val_q;
          8'h03: rd_d = {24'h0, ctl_q};
          8'h04: rd_d = init_val_q;
          8'h06: rd_d = {31'h0, cmp_mode_q};
          8'h07: rd_d = {16'h0, samp_ms_q};
          default: rd_d = 32'h0;
        endcase
      end
      IDX_MODULE_OPERATING_MODE: rd_d = {24'h0, mode_q};
      IDX_DI2_FUNCTION: rd_d = {24'h0, di2_func_q};
      IDX_CAM_ENABLE: rd_d = {16'h0, cam_en_q};
      default: rd_d = 32'h0;
    endcase
  end
  logic [31:0] rd_hold_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_hold_q <= 32'h0;
      rd_cam_q <= 1'b0;
    end else begin
      rd_hold_q <= bus.rd ? rd_d : 32'h0;
      rd_cam_q <= bus.rd && idx == IDX_CAM_SWITCH_TABLE && sub != 8'h00
        && sub <= 8'(CAM_N * CAM_SUBS);
    end
  end
  assign rdata = rd_cam_q ? cam_rdata : rd_hold_q;
endmodule
`default_nettype wire
